// >>> rtl/usi_params.svh
`ifndef USI_PARAMS_SVH
`define USI_PARAMS_SVH
// ==================================================
// Register map (byte addresses, one word each)
`define USI_OFF_CTRL      12'h000
`define USI_OFF_OBJ       12'h004
`define USI_OFF_LOCAL     12'h008
`define USI_OFF_STATUS    12'h00C
// ==================================================
// Control register fields
`define USI_CTRL_UNIT     1:0
`define USI_CTRL_REMOTE   2
`define USI_CTRL_CHG      3
`define USI_CTRL_CFG      4
`define USI_CTRL_DL       5
`define USI_CTRL_RST      6
`define USI_CTRL_BOOST    7
`define USI_CTRL_MASTER   8
`define USI_CTRL_PSS      9
`define USI_CTRL_ACK      10
`define USI_CTRL_TXEN     11
`define USI_CTRL_TXDIS    12
`define USI_CTRL_EXT      13
// ==================================================
// Managed object report fields
`define USI_OBJ_FUNC      0
`define USI_OBJ_CTLR      1
`define USI_OBJ_RCV       2
`define USI_OBJ_SLOT      3
`define USI_OBJ_RESET     4
// ==================================================
// Local status fields
`define USI_LOC_FUNC_FLT  0
`define USI_LOC_CTLR_OK   1
`define USI_LOC_CFG_DONE  2
`define USI_LOC_EXT_OK    3
`define USI_LOC_SUB_FLT   4
// ==================================================
// Timing
`define USI_CLK_HZ        200000000
`define USI_BLINK_HALF_MS 1000
`define USI_START_OFF_MS  2000
`define USI_CTRL_RST_VAL  32'h0000_0000
`endif

// >>> rtl/usi_pkg.sv
package usi_pkg;
   typedef enum logic [1:0] {
      USI_CENTRAL,
      USI_TRANSCEIVER,
      USI_ENVIRONMENT,
      USI_SUBORDINATE
   } usi_unit_t;
   typedef struct packed {
      logic green;
      logic yellow;
   } usi_lamps_t;
endpackage : usi_pkg

// >>> rtl/usi_indicator.sv
`timescale 1ns/10ps
`include "usi_params.svh"
// Summary of operation
// - Blink operational lamp during software download
// - Blink during controller configuration job
// - Blink while restart pending after download
// - Blink beats on; on beats off
// - Otherwise lit if operational, else dark
// - Lamp off two to ten seconds after start
// - Any reset ends control of both lamps
// - Remote master cabinet needs four object kinds
// - Remote transceiver needs controller, receiver, timeslot
// - Boost slave lamp follows master lamp in remote mode only
// - Object out of operation on reset, local
// - Environment unit lamp from local faults only
// - Local master needs function, controller, configuration
// - Subordinate operational when no class 1 faults
// - Local extension cabinet needs controller, configuration
// - Remote handling ends after acknowledgement sent
// - Not operational during mode change, except environment and subordinate units
// - Environment and subordinate units stay local
// - Tx lamp lit until transmitter enabled
// - Tx lamp on when transmitter disabled
// - Remote report only in remote, permitted state
module usi_indicator #(
   parameter int BLINK_HALF_CYC = (`USI_CLK_HZ / 1000) * `USI_BLINK_HALF_MS,
   parameter int START_OFF_CYC  = (`USI_CLK_HZ / 1000) * `USI_START_OFF_MS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        master_lamp,
   output logic             green_lamp,
   output logic             yellow_lamp
);
   // ==================================================
   // Bus decode
   wire        acc      = psel & penable;
   wire        wr       = acc & pwrite;
   wire        hit_ctrl = (paddr == `USI_OFF_CTRL);
   wire        hit_obj  = (paddr == `USI_OFF_OBJ);
   wire        hit_loc  = (paddr == `USI_OFF_LOCAL);
   wire        hit_st   = (paddr == `USI_OFF_STATUS);
   wire        mapped   = hit_ctrl | hit_obj | hit_loc | hit_st;

   logic [31:0] ctrl_q;
   logic [3:0]  obj_q;
   logic [4:0]  loc_q;
   logic        tx_off_q;
   logic        started_q;
   logic [31:0] start_cnt_q;
   logic [31:0] blink_cnt_q;
   logic        phase_q;
   logic        green_q;
   logic        yellow_q;
   logic        remote_done_q;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ==================================================
   // Mode and conditions
   wire [1:0] unit_w  = ctrl_q[`USI_CTRL_UNIT];
   wire       is_env  = (unit_w == 2'(usi_pkg::USI_ENVIRONMENT));
   wire       is_sub  = (unit_w == 2'(usi_pkg::USI_SUBORDINATE));
   wire       is_cen  = (unit_w == 2'(usi_pkg::USI_CENTRAL));
   // Remote mode is refused for units that must stay local
   wire       remote  = ctrl_q[`USI_CTRL_REMOTE] & ~is_env & ~is_sub;
   wire       chg     = ctrl_q[`USI_CTRL_CHG];
   // Reports accepted only in remote, permitted state, before acknowledge
   wire       obj_wr  = wr & hit_obj & remote & ctrl_q[`USI_CTRL_PSS] & ~remote_done_q;
   wire       blink_c = ctrl_q[`USI_CTRL_DL] | ctrl_q[`USI_CTRL_CFG] | ctrl_q[`USI_CTRL_RST];
   wire       rem_trx = obj_q[`USI_OBJ_CTLR] & obj_q[`USI_OBJ_RCV] & obj_q[`USI_OBJ_SLOT];
   wire       rem_cen = obj_q[`USI_OBJ_FUNC] & rem_trx;
   wire       loc_trx = loc_q[`USI_LOC_CTLR_OK] & loc_q[`USI_LOC_CFG_DONE];
   wire       loc_ext = ~ctrl_q[`USI_CTRL_EXT] | loc_q[`USI_LOC_EXT_OK];
   wire       loc_cen = ~loc_q[`USI_LOC_FUNC_FLT] & loc_trx & loc_ext;
   wire       loc_ok  = ~loc_q[`USI_LOC_SUB_FLT];
   logic      oper;
   always_comb begin
      if (chg & ~is_env & ~is_sub)
         oper = 1'b0;
      else if (is_env | is_sub)
         oper = loc_ok;
      else if (remote & ctrl_q[`USI_CTRL_BOOST] & ~ctrl_q[`USI_CTRL_MASTER] & ~is_cen)
         oper = master_lamp;
      else if (remote)
         oper = is_cen ? rem_cen : rem_trx;
      else
         oper = is_cen ? loc_cen : loc_trx;
   end
   // Flashing first, then steady on, else dark; dark until start window ends
   wire green_d = ~started_q ? 1'b0 : (blink_c ? phase_q : oper);

   // ==================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `USI_CTRL_RST_VAL;
      end else if (wr & hit_ctrl) begin
         ctrl_q <= pwdata;
      end
   end

   // Objects drop out on reset or when the unit goes local
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         obj_q <= 4'h0;
      end else if (~remote | (obj_wr & pwdata[`USI_OBJ_RESET])) begin
         obj_q <= 4'h0;
      end else if (obj_wr) begin
         obj_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loc_q <= 5'h00;
      end else if (wr & hit_loc) begin
         loc_q <= pwdata[4:0];
      end
   end

   // Acknowledge ends remote handling until the unit leaves remote mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_done_q <= 1'b0;
      end else if (~remote) begin
         remote_done_q <= 1'b0;
      end else if (wr & hit_ctrl & pwdata[`USI_CTRL_ACK]) begin
         remote_done_q <= 1'b1;
      end
   end

   // Disable wins over enable when both arrive together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_off_q <= 1'b1;
      end else if (wr & hit_ctrl & pwdata[`USI_CTRL_TXDIS]) begin
         tx_off_q <= 1'b1;
      end else if (wr & hit_ctrl & pwdata[`USI_CTRL_TXEN]) begin
         tx_off_q <= 1'b0;
      end
   end

   // ==================================================
   // Start window and flash divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_cnt_q <= 32'h0000_0000;
         started_q   <= 1'b0;
      end else if (!started_q) begin
         start_cnt_q <= start_cnt_q + 32'h0000_0001;
         started_q   <= (start_cnt_q == 32'(START_OFF_CYC - 1));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt_q <= 32'h0000_0000;
         phase_q     <= 1'b0;
      end else if (blink_cnt_q == 32'(BLINK_HALF_CYC - 1)) begin
         blink_cnt_q <= 32'h0000_0000;
         phase_q     <= ~phase_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
   end

   // Reset drives both lamps dark; a reset ends all lamp state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         green_q  <= 1'b0;
         yellow_q <= 1'b0;
      end else begin
         green_q  <= green_d;
         yellow_q <= tx_off_q;
      end
   end

   assign green_lamp  = green_q;
   assign yellow_lamp = yellow_q;

   wire [31:0] status_w = {26'h000_0000, remote_done_q, remote, oper, phase_q, yellow_q, green_q};
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_ctrl)
         prdata = ctrl_q;
      else if (hit_obj)
         prdata = {28'h000_0000, obj_q};
      else if (hit_loc)
         prdata = {27'h000_0000, loc_q};
      else if (hit_st)
         prdata = status_w;
   end

   // ==================================================
   // Checks: flashing and start window
   chk_blink_wins: assert property (@(posedge pclk) disable iff (!presetn)
      started_q && blink_c
      |=> green_q == $past(phase_q))
      else $error("blink not followed");

   chk_oper_steady: assert property (@(posedge pclk) disable iff (!presetn)
      started_q && !blink_c
      |=> green_q == $past(oper))
      else $error("steady lamp wrong");

   chk_start_dark: assert property (@(posedge pclk) disable iff (!presetn)
      !started_q
      |=> !green_q)
      else $error("lamp lit before start");

   chk_download_blink: assert property (@(posedge pclk) disable iff (!presetn)
      started_q && ctrl_q[`USI_CTRL_DL]
      |=> green_q == $past(phase_q))
      else $error("no flash during download");

   chk_config_blink: assert property (@(posedge pclk) disable iff (!presetn)
      started_q && ctrl_q[`USI_CTRL_CFG]
      |=> green_q == $past(phase_q))
      else $error("no flash during configuration");

   chk_restart_blink: assert property (@(posedge pclk) disable iff (!presetn)
      started_q && ctrl_q[`USI_CTRL_RST]
      |=> green_q == $past(phase_q))
      else $error("no flash while restart pending");

   chk_phase_period: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(phase_q)
      |=> $stable(phase_q))
      else $error("phase toggles too fast");

   chk_phase_count: assert property (@(posedge pclk) disable iff (!presetn)
      blink_cnt_q == 32'(BLINK_HALF_CYC - 1)
      |=> phase_q != $past(phase_q))
      else $error("phase missed its toggle");

   chk_start_length: assert property (@(posedge pclk) disable iff (!presetn)
      !started_q && start_cnt_q == 32'(START_OFF_CYC - 1)
      |=> started_q)
      else $error("start window not closed");

   // ==================================================
   // Checks: operational state
   chk_chg_notop: assert property (@(posedge pclk) disable iff (!presetn)
      chg && !is_env && !is_sub
      |-> !oper)
      else $error("operational during change");

   chk_remote_central: assert property (@(posedge pclk) disable iff (!presetn)
      remote && !chg && is_cen
      |-> oper == (obj_q[`USI_OBJ_FUNC] && obj_q[`USI_OBJ_CTLR] && obj_q[`USI_OBJ_RCV] && obj_q[`USI_OBJ_SLOT]))
      else $error("remote central state wrong");

   chk_remote_transceiver: assert property (@(posedge pclk) disable iff (!presetn)
      remote && !chg && !is_cen && (!ctrl_q[`USI_CTRL_BOOST] || ctrl_q[`USI_CTRL_MASTER])
      |-> oper == (obj_q[`USI_OBJ_CTLR] && obj_q[`USI_OBJ_RCV] && obj_q[`USI_OBJ_SLOT]))
      else $error("remote transceiver state wrong");

   chk_boost_follow: assert property (@(posedge pclk) disable iff (!presetn)
      remote && !chg && ctrl_q[`USI_CTRL_BOOST] && !ctrl_q[`USI_CTRL_MASTER] && !is_cen
      |-> oper == master_lamp)
      else $error("slave lamp differs");

   chk_local_central: assert property (@(posedge pclk) disable iff (!presetn)
      !remote && !chg && is_cen
      |-> oper == (!loc_q[`USI_LOC_FUNC_FLT] && loc_q[`USI_LOC_CTLR_OK] && loc_q[`USI_LOC_CFG_DONE] && loc_ext))
      else $error("local central state wrong");

   chk_ext_cabinet: assert property (@(posedge pclk) disable iff (!presetn)
      !remote && is_cen && ctrl_q[`USI_CTRL_EXT] && !loc_q[`USI_LOC_EXT_OK]
      |-> !oper)
      else $error("extension cabinet ignored");

   chk_env_local: assert property (@(posedge pclk) disable iff (!presetn)
      is_env
      |-> oper == !loc_q[`USI_LOC_SUB_FLT])
      else $error("environment lamp not local");

   chk_sub_local: assert property (@(posedge pclk) disable iff (!presetn)
      is_sub
      |-> oper == !loc_q[`USI_LOC_SUB_FLT])
      else $error("subordinate state wrong");

   chk_stay_local: assert property (@(posedge pclk) disable iff (!presetn)
      is_env || is_sub
      |-> !remote)
      else $error("local-only unit went remote");

   // ==================================================
   // Checks: object reports
   chk_local_object: assert property (@(posedge pclk) disable iff (!presetn)
      !remote
      |=> obj_q == 4'h0)
      else $error("object kept in local");

   chk_object_reset: assert property (@(posedge pclk) disable iff (!presetn)
      obj_wr && pwdata[`USI_OBJ_RESET]
      |=> obj_q == 4'h0)
      else $error("object kept over reset");

   chk_object_load: assert property (@(posedge pclk) disable iff (!presetn)
      obj_wr && !pwdata[`USI_OBJ_RESET]
      |=> obj_q == $past(pwdata[3:0]))
      else $error("report not taken");

   chk_ack_block: assert property (@(posedge pclk) disable iff (!presetn)
      remote_done_q && remote && wr && hit_obj
      |=> $stable(obj_q))
      else $error("report after ack");

   chk_no_permit: assert property (@(posedge pclk) disable iff (!presetn)
      remote && !ctrl_q[`USI_CTRL_PSS] && wr && hit_obj
      |=> $stable(obj_q))
      else $error("report outside permitted state");

   chk_ack_set: assert property (@(posedge pclk) disable iff (!presetn)
      remote && wr && hit_ctrl && pwdata[`USI_CTRL_ACK]
      |=> remote_done_q)
      else $error("ack not recorded");

   // ==================================================
   // Checks: transmitter lamp
   chk_tx_dis: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl && pwdata[`USI_CTRL_TXDIS]
      |=> ##1 yellow_q)
      else $error("tx lamp not on");

   chk_tx_en: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl && pwdata[`USI_CTRL_TXEN] && !pwdata[`USI_CTRL_TXDIS]
      |=> ##1 !yellow_q)
      else $error("tx lamp not off");

   chk_tx_on: assert property (@(posedge pclk) disable iff (!presetn)
      tx_off_q
      |=> yellow_q)
      else $error("tx lamp dark while disabled");

   chk_tx_off: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_off_q
      |=> !yellow_q)
      else $error("tx lamp lit while enabled");

endmodule : usi_indicator

// >>> dv/usi_ctrl_model.sv
`timescale 1ns/10ps
// ==================================================
// Controller side: speaks APB to the unit, one idle edge between transfers
module usi_ctrl_model (
   input  wire logic        pclk,
   input  wire logic        pready,
   output logic             psel    = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite  = 1'b0,
   output logic      [11:0] paddr   = 12'h000,
   output logic      [31:0] pwdata  = 32'h0000_0000
);
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines scramble so stale values cannot pass for live ones
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer
endmodule : usi_ctrl_model

// >>> dv/unit_status_indicator_control_tb_top.sv
`timescale 1ns/10ps
`include "usi_params.svh"
module unit_status_indicator_control_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        master_lamp = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, green_lamp, yellow_lamp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [64:0] exp_q[$];
   logic [64:0] cur;
   int          fail_count = 0;
   int          n_checks = 0;
   always #2.5 pclk = ~pclk;
   usi_ctrl_model u_usi_ctrl_model (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   usi_indicator #(.BLINK_HALF_CYC(8), .START_OFF_CYC(20)) u_usi_indicator (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .master_lamp(master_lamp), .green_lamp(green_lamp),
      .yellow_lamp(yellow_lamp));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Expectation noted before the transfer: {error, read mask, read value}
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic s, input logic [31:0] m,
            input logic [31:0] v);
      exp_q.push_back({s, m, v});
      u_usi_ctrl_model.xfer(w, a, d);
   endtask : acc
   task wr(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 1'b0, 32'h0000_0000, 32'h0000_0000);
   endtask : wr
   task rd(input logic [31:0] m, input logic [31:0] v);
      acc(1'b0, `USI_OFF_STATUS, 32'h0000_0000, 1'b0, m, v);
   endtask : rd
   // Half period of 8 cycles gives exactly four lamp changes in 32 cycles
   task blink;
      int   n;
      logic p;
      n = 0;
      // Start from the first lamp value after the write, so the switch into flashing is not counted
      @(posedge pclk);
      #1;
      p = green_lamp;
      repeat (32) begin
         @(posedge pclk);
         #1;
         n += int'(green_lamp !== p);
         p = green_lamp;
      end
      chk("blink", n, 4);
   endtask : blink
   // ==================================================
   // Monitor: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         cur = exp_q.pop_front();
         chk("pslverr", {31'h0, pslverr}, {31'h0, cur[64]});
         chk("prdata", prdata & cur[63:32], cur[31:0]);
      end
   end
   initial begin
      #(5 * 20000);
      fail_count++;
      end_of_test();
   end
   // ==================================================
   // Main sequence
   initial begin
      r = $urandom(36023);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk("yellow", {31'h0, yellow_lamp}, 32'h0000_0001);
      wr(`USI_OFF_LOCAL, 32'h0000_0006);
      rd(32'h0000_0001, 32'h0000_0000);
      repeat (30) @(posedge pclk);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_LOCAL, 32'h0000_0007);
      rd(32'h0000_0001, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         wr(`USI_OFF_CTRL, 32'h0000_0010 << i);
         blink();
      end
      wr(`USI_OFF_LOCAL, 32'h0000_0006);
      blink();
      wr(`USI_OFF_CTRL, 32'h0000_0000);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_CTRL, 32'h0000_0204);
      repeat (8) begin
         r = $urandom & 32'h0000_000F;
         wr(`USI_OFF_OBJ, r);
         rd(32'h0000_0001, {31'h0, &r[3:0]});
      end
      wr(`USI_OFF_OBJ, 32'h0000_000F);
      wr(`USI_OFF_CTRL, 32'h0000_020C);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0204);
      wr(`USI_OFF_OBJ, 32'h0000_001F);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_OBJ, 32'h0000_000F);
      wr(`USI_OFF_CTRL, 32'h0000_0604);
      wr(`USI_OFF_OBJ, 32'h0000_0000);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_CTRL, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0204);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0004);
      wr(`USI_OFF_OBJ, 32'h0000_000F);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0205);
      wr(`USI_OFF_OBJ, 32'h0000_000E);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_OBJ, 32'h0000_0006);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0285);
      repeat (4) begin
         @(posedge pclk);
         master_lamp <= 1'($urandom);
         @(posedge pclk);
         rd(32'h0000_0001, {31'h0, master_lamp});
      end
      wr(`USI_OFF_LOCAL, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0206);
      wr(`USI_OFF_OBJ, 32'h0000_0000);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_LOCAL, 32'h0000_0010);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0007);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_LOCAL, 32'h0000_0000);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_CTRL, 32'h0000_2000);
      wr(`USI_OFF_LOCAL, 32'h0000_0006);
      rd(32'h0000_0001, 32'h0000_0000);
      wr(`USI_OFF_LOCAL, 32'h0000_000E);
      rd(32'h0000_0001, 32'h0000_0001);
      wr(`USI_OFF_CTRL, 32'h0000_0800);
      rd(32'h0000_0002, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_1000);
      rd(32'h0000_0002, 32'h0000_0002);
      wr(`USI_OFF_CTRL, 32'h0000_0800);
      wr(`USI_OFF_CTRL, 32'h0000_1800);
      rd(32'h0000_0002, 32'h0000_0002);
      acc(1'b1, 12'h010, 32'h0000_FFFF, 1'b1, 32'h0000_0000, 32'h0000_0000);
      wr(`USI_OFF_CTRL, 32'h0000_0800);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      chk("lamps", {30'h0, green_lamp, yellow_lamp}, 32'h0000_0000);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk("yellow", {31'h0, yellow_lamp}, 32'h0000_0001);
      chk("green", {31'h0, green_lamp}, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      end_of_test();
   end
endmodule : unit_status_indicator_control_tb_top
